// [verilog/sar_ctrl_pkg.sv]
// Purpose: Shared constants and types for the converter sequencing and readout block
// Assumes: 50 MHz core clock
// Notes: Times are held in their printed units; cycle counts derive from them
package sar_ctrl_pkg;
    localparam int RESULT_BITS = 18;
    localparam int CLK_MHZ = 50;
    // Times in ns
    localparam int POR_WAIT_NS = 20000;
    localparam int CONV_MAX_NS = 1500;
    localparam int ACQ_START_NS = 527;
    localparam int START_WINDOW_NS = 40;
    // Longest times round down, least times round up
    localparam int CONV_CYCLES = (CONV_MAX_NS * CLK_MHZ) / 1000;
    localparam int ACQ_START_CYCLES = (ACQ_START_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_WAIT_CYCLES = (POR_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [RESULT_BITS-1:0] RESULT_RESET = 18'h00000;

    // Serial output pin as data and active-low enable, registered together
    typedef struct packed {
        logic data;
        logic oe_n;
    } sdo_pin_t;
endpackage

// [verilog/sar_conv_readout.sv]
// Purpose: Conversion sequencing and serial readout of an 18-bit SAR converter
// Assumes: convert_start, sck, read_select_input and chain mode come from outside and are synchronised here
// Notes: The analog core is modelled by sample_code_i, captured at conversion start
`timescale 1ns/10ps

module sar_conv_readout
    import sar_ctrl_pkg::*;
#(
    parameter int POR_WAIT = POR_WAIT_CYCLES
) (
    // Clock and supply-monitor reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host control pins
    input wire logic convert_start_i,
    input wire logic sck_i,
    input wire logic read_select_input_i,
    input wire logic chain_mode_select_i,
    // Analog core result, straight binary
    input wire logic [RESULT_BITS-1:0] sample_code_i,
    // Status and serial output
    output logic busy_o,
    output logic powered_up_o,
    output logic acquiring_o,
    output logic ready_o,
    output logic sdo_o,
    output logic sdo_oe_n_o
);

    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CONV} state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; only the second stage is read by logic
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sck_d_reg;
    logic cnv_d_reg;

    // Select resets to its idle high level, so the pin is not briefly driven after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 4'h4;
            sync2_reg <= 4'h4;
            sck_d_reg <= 1'b0;
            cnv_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {chain_mode_select_i, read_select_input_i, sck_i, convert_start_i};
            sync2_reg <= sync1_reg;
            sck_d_reg <= sync2_reg[1];
            cnv_d_reg <= sync2_reg[0];
        end
    end

    logic cnv_s;
    logic sck_s;
    logic sel_s;
    logic chain_s;
    logic cnv_rise;
    logic sck_rise;
    assign cnv_s = sync2_reg[0];
    assign sck_s = sync2_reg[1];
    assign sel_s = sync2_reg[2];
    assign chain_s = sync2_reg[3];
    assign cnv_rise = cnv_s & ~cnv_d_reg;
    assign sck_rise = sck_s & ~sck_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    state_t state_reg;
    logic [15:0] timer_reg;
    logic [RESULT_BITS-1:0] sample_reg;
    logic conv_done;
    assign conv_done = (state_reg == ST_CONV) && (timer_reg == 16'(CONV_CYCLES - 1));

    // Reset restarts the reinit wait; starts during it are dropped as invalid
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_INIT;
            timer_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    if (timer_reg == 16'(POR_WAIT - 1)) begin
                        state_reg <= ST_IDLE;
                        timer_reg <= 16'h0000;
                    end else begin
                        timer_reg <= timer_reg + 16'h0001;
                    end
                end
                ST_IDLE: begin
                    if (cnv_rise) begin
                        state_reg <= ST_CONV;
                        timer_reg <= 16'h0000;
                    end
                end
                ST_CONV: begin
                    // Edges here are ignored, so the host need not be careful
                    if (conv_done) begin
                        state_reg <= ST_IDLE;
                        timer_reg <= 16'h0000;
                    end else begin
                        timer_reg <= timer_reg + 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_INIT;
                    timer_reg <= 16'h0000;
                end
            endcase
        end
    end

    // Sample held at conversion start, straight binary from the core
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_reg <= RESULT_RESET;
        end else if (state_reg == ST_IDLE && cnv_rise) begin
            sample_reg <= sample_code_i;
        end
    end

    // Status outputs, all registered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            powered_up_o <= 1'b0;
            acquiring_o <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            busy_o <= (state_reg == ST_IDLE && cnv_rise) || (state_reg == ST_CONV && !conv_done);
            powered_up_o <= (state_reg == ST_IDLE && cnv_rise) || (state_reg == ST_CONV && !conv_done);
            // Next sample acquisition overlaps the tail of conversion
            acquiring_o <= (state_reg == ST_IDLE && !cnv_rise)
                || (state_reg == ST_CONV && timer_reg >= 16'(ACQ_START_CYCLES - 1));
            ready_o <= (state_reg != ST_INIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output shift register; MSB is always the bit on the pin
    logic [RESULT_BITS-1:0] shift_reg;
    logic out_en;
    assign out_en = chain_s | ~sel_s;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= RESULT_RESET;
        end else if (conv_done) begin
            shift_reg <= sample_reg;
        end else if (sck_rise && out_en) begin
            // Chain input enters at the tail behind the own result
            shift_reg <= {shift_reg[RESULT_BITS-2:0], chain_s & sel_s};
        end
    end
    // Kept between conversions, so the last result stays readable
    // The register is never cleared by a conversion start: a host may still
    // be reading the previous result while the next conversion runs.

    ////////////////////////////////////////////////////////////////////////////
    // Output pin
    // Next pin state gathered in one carrier so data and enable move together
    sdo_pin_t pin_next;

    always_comb begin
        pin_next.data = shift_reg[RESULT_BITS-1];
        pin_next.oe_n = ~out_en;
        if (conv_done) begin
            // The fresh MSB must reach the pin at the same edge busy falls
            pin_next.data = sample_reg[RESULT_BITS-1];
        end
    end

    // Pin follows the register MSB; enable follows the synchronised mode and select one core cycle later
    // Registering both costs one core cycle of delay but keeps the pin glitch free
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
            sdo_oe_n_o <= 1'b1;
        end else begin
            sdo_o <= pin_next.data;
            sdo_oe_n_o <= pin_next.oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Check helpers
    // A cycle counter stands in for a long repetition, which the tools would
    // otherwise have to unroll 75 times
    logic [7:0] busy_len_reg;

    // Length of the current busy pulse, counted on the registered output
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_len_reg <= 8'h00;
        end else if (busy_o) begin
            busy_len_reg <= busy_len_reg + 8'h01;
        end else begin
            busy_len_reg <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_busy_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_o) |-> busy_o [*8] ##1 busy_o [*8])
        else $error("busy dropped early");
    a_conv_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_o) |-> ##[1:80] !busy_o)
        else $error("conversion too long");
    a_ignore_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == ST_CONV && cnv_rise && !conv_done) |=> state_reg == ST_CONV)
        else $error("start during conversion not ignored");
    a_start_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == ST_IDLE && cnv_rise) |=> busy_o && powered_up_o)
        else $error("start edge missed");
    a_powerdown_acq: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> !powered_up_o && acquiring_o)
        else $error("no power down after conversion");
    a_acq_early: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_o) |-> ##27 acquiring_o)
        else $error("acquisition not started in time");
    a_hiz_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (!chain_s && sel_s) |=> sdo_oe_n_o)
        else $error("output driven while deselected");
    a_chain_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        chain_s |=> !sdo_oe_n_o)
        else $error("chain mode output not driven");
    a_msb_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> sdo_o == sample_reg[RESULT_BITS-1])
        else $error("new msb missing at end of conversion");
    a_shift_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!sck_rise && !conv_done) |=> $stable(shift_reg))
        else $error("shift without clock");
    a_init_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_o |-> !busy_o)
        else $error("conversion during reinit");
    a_init_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_o |-> !powered_up_o)
        else $error("core powered during reinit");

    // Busy must last exactly the conversion time, never more
    a_busy_exact: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> busy_len_reg == 8'(CONV_CYCLES))
        else $error("busy length wrong");
    a_busy_max: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o |-> busy_len_reg < 8'(CONV_CYCLES))
        else $error("busy beyond conversion limit");

    // Acquisition must not start early either, or the held sample is disturbed
    a_acq_late: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_o && busy_len_reg < 8'(ACQ_START_CYCLES)) |-> !acquiring_o)
        else $error("acquisition started too early");
    a_acq_held: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_o && busy_len_reg >= 8'(ACQ_START_CYCLES)) |-> acquiring_o)
        else $error("acquisition dropped during conversion");
    a_back_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> state_reg == ST_IDLE)
        else $error("not idle after conversion");

    // Capture and load of the result
    a_sample_take: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == ST_IDLE && cnv_rise) |=> sample_reg == $past(sample_code_i))
        else $error("sample not captured at start");
    a_load_result: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done |=> shift_reg == $past(sample_reg))
        else $error("result not loaded");

    // Shifting: each step moves the next bit up, chain data enters at the tail
    a_shift_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (sck_rise && out_en && !conv_done) |=> shift_reg[RESULT_BITS-1] == $past(shift_reg[RESULT_BITS-2]))
        else $error("shift order wrong");
    a_chain_input: assert property (@(posedge clk_i) disable iff (rst_i)
        (sck_rise && chain_s && !conv_done) |=> shift_reg[0] == $past(sel_s))
        else $error("chain input not captured");
    a_normal_fill: assert property (@(posedge clk_i) disable iff (rst_i)
        (sck_rise && !chain_s && !sel_s && !conv_done) |=> !shift_reg[0])
        else $error("normal mode fill not zero");
    a_pin_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        !conv_done |=> sdo_o == $past(shift_reg[RESULT_BITS-1]))
        else $error("pin does not follow shift msb");

    c_conversion: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy_o));
    c_normal_read: cover property (@(posedge clk_i) disable iff (rst_i) sck_rise && !sel_s && !chain_s);
    c_chain_read: cover property (@(posedge clk_i) disable iff (rst_i) sck_rise && chain_s && sel_s);
    c_ignored_start: cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_CONV && cnv_rise);
    c_acq_overlap: cover property (@(posedge clk_i) disable iff (rst_i) busy_o && acquiring_o);

endmodule

// [bench/sar_host_model.sv]
// Purpose: Host controller model driving start, serial clock and select pins
// Assumes: Pins change only at falling edges of the core clock
// Notes: Serial clock stands low outside read frames
`timescale 1ns/10ps
module sar_host_model (
    // Core clock
    input wire logic clk_i,
    // Device pins
    output logic convert_start_o,
    output logic sck_o,
    output logic read_select_input_o,
    output logic chain_mode_select_o
);
////////////////////////////////////////////////////////////////////////////////
    // Select idles high so a shared output stays released
    initial begin
        convert_start_o = 1'b0;
        sck_o = 1'b0;
        read_select_input_o = 1'b1;
        chain_mode_select_o = 1'b0;
    end
    // Static pin levels
    task automatic set_pins(input logic convert_start, input logic sel, input logic chain);
        convert_start_o = convert_start;
        read_select_input_o = sel;
        chain_mode_select_o = chain;
    endtask
    // One cycle wide start; its fall stays inside the 40 ns window
    task automatic pulse_cnv();
        @(negedge clk_i);
        convert_start_o = 1'b1;
        @(negedge clk_i);
        convert_start_o = 1'b0;
    endtask
    // One 160 ns serial period; data in settles a cycle before the rise
    // Slower than the advised 40MHz, since the core clock must see each level
    task automatic clock_bit(input logic sdi);
        read_select_input_o = sdi;
        @(negedge clk_i);
        sck_o = 1'b1;
        repeat (4) @(negedge clk_i);
        sck_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

// [bench/sar_adc_conversion_serial_readout_test.sv]
// Purpose: Self-checking bench for conversion sequencing and serial readout
// Assumes: Reinit wait shortened to 20 cycles
// Notes: Outputs are sampled at falling clock edges
`timescale 1ns/10ps
module sar_adc_conversion_serial_readout_test;
    import sar_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [RESULT_BITS-1:0] code = 18'h00000;
    logic busy_o, powered_up_o, acquiring_o, ready_o, sdo_o, sdo_oe_n_o, convert_start, sck, sel, chain;
    int failures = 0;
    int n_tests = 0;
    always #10 clk_i = ~clk_i;
    sar_host_model host (.clk_i(clk_i), .convert_start_o(convert_start), .sck_o(sck), .read_select_input_o(sel),
        .chain_mode_select_o(chain));
    sar_conv_readout #(.POR_WAIT(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .convert_start_i(convert_start), .sck_i(sck),
        .read_select_input_i(sel), .chain_mode_select_i(chain), .sample_code_i(code), .busy_o(busy_o),
        .powered_up_o(powered_up_o), .acquiring_o(acquiring_o), .ready_o(ready_o), .sdo_o(sdo_o),
        .sdo_oe_n_o(sdo_oe_n_o));
////////////////////////////////////////////////////////////////////////////////
    // Shared compare; four-state so an unknown never matches
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_level(ref logic sig, input logic v, input int lim);
        for (int n = 0; n < lim && sig !== v; n++) @(negedge clk_i);
        if (sig !== v) begin
            failures++;
            $display("Error at %0t: wait ran out", $time);
            complete_run();
        end
    endtask
    // Start one conversion, time busy and acquisition, optionally poke start again 40 ns after the first
    task automatic run_conv(input logic [17:0] c, input logic extra);
        int n, acq;
        n = 0;
        acq = 0;
        code = c;
        host.pulse_cnv();
        // Second rise 40 ns after the first, inside the allowed window
        if (extra) begin
            @(negedge clk_i);
            host.set_pins(1'b1, sel, chain);
        end
        wait_level(busy_o, 1'b1, 10);
        while (busy_o === 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
            if (acq == 0 && acquiring_o === 1'b1) acq = n;
        end
        if (extra) host.set_pins(1'b0, sel, chain);
        check(18'(n), 18'(CONV_CYCLES));
        check(18'(acq), 18'(ACQ_START_CYCLES));
        check({powered_up_o, acquiring_o}, 18'h00001);
    endtask
    // First compare precedes any serial clock; chain bits follow from up
    task automatic read_bits(input logic [35:0] exp, input int nb, input logic [17:0] up);
        for (int i = 0; i < nb; i++) begin
            check(sdo_o, exp[35-i]);
            host.clock_bit(i < 18 ? up[17-i] : 1'b0);
        end
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check({busy_o, powered_up_o, acquiring_o, ready_o, sdo_o, sdo_oe_n_o}, 18'h00001);
        rst_i = 1'b0;
        host.pulse_cnv();
        repeat (8) @(negedge clk_i);
        check(busy_o, 1'b0);
        wait_level(ready_o, 1'b1, 60);
        $display("Reset test done");
    endtask
    // Selected readout after an idle gap; each load replaces the last result
    task automatic test_normal();
        logic [17:0] codes [3] = '{18'h2D5A3, 18'h3FFFF, 18'h00000};
        host.set_pins(1'b0, 1'b0, 1'b0);
        foreach (codes[k]) begin
            run_conv(codes[k], 1'b1);
            check({sdo_oe_n_o, sdo_o}, {1'b0, codes[k][17]});
            repeat (40) @(negedge clk_i);
            read_bits({codes[k], 18'h00000}, 18, 18'h00000);
        end
        $display("Normal mode test done");
    endtask
    // Deselected clocks must not shift; selecting shows the MSB at once
    task automatic test_select();
        host.set_pins(1'b0, 1'b1, 1'b0);
        run_conv(18'h1B3C5, 1'b0);
        check(sdo_oe_n_o, 1'b1);
        host.clock_bit(1'b1);
        host.clock_bit(1'b1);
        host.set_pins(1'b0, 1'b0, 1'b0);
        repeat (5) @(negedge clk_i);
        check(sdo_oe_n_o, 1'b0);
        read_bits({18'h1B3C5, 18'h00000}, 18, 18'h00000);
        $display("Select test done");
    endtask
    task automatic test_chain();
        host.set_pins(1'b0, 1'b1, 1'b1);
        repeat (5) @(negedge clk_i);
        check(sdo_oe_n_o, 1'b0);
        run_conv(18'h0F0F3, 1'b0);
        read_bits({18'h0F0F3, 18'h35A69}, 36, 18'h35A69);
        $display("Chain mode test done");
    endtask
    // Reset held 10 cycles, then each scenario in turn
    initial begin
        repeat (10) @(negedge clk_i);
        test_reset();
        test_normal();
        test_select();
        test_chain();
        complete_run();
    end
endmodule
